// >>> rtl/ecc_map.vh
`ifndef ECC_MAP_VH
`define ECC_MAP_VH

// Field arithmetic over GF(256), primitive polynomial low byte and generator.
`define GF_POLY 8'h1D
`define GF_ALPHA 8'h02

// Symbol store: 8-bit words, 2K deep, 32 symbols to a frame slot.
`define RAM_AW 11
`define RAM_DW 8
`define FRAME_AW 6
`define SYM_AW 5

// Codeword lengths of the two stages and their last symbol indices.
`define C1_LEN 32
`define C2_LEN 28
`define C1_LAST 5'h1F
`define C2_LAST 5'h1B

// Flag count thresholds used by the second stage.
`define C2_FLAG_MANY 6'h07
`define C2_FLAG_FEW 6'h02

// Jitter window in frames and nominal read lag behind the writer.
`define JIT_FRAMES 6'h04
`define RD_LAG 6'h08

// Interleave delay of the second stage, in frames per symbol index.
`define C2_DLY 1

// Frame interval at normal speed and the core clock period, both in ns.
`define FRAME_NS 136054
`define CLK_NS 10

`endif

// >>> rtl/sym_ram.v
`default_nettype none
// Two-port store: port a is write-only for the upstream writer, port b reads and writes for the corrector.
// A write on port b lands after a port a write to the same word in the same cycle.
module sym_ram #(
    parameter AW = 11,
    parameter DW = 8
) (
    input wire clk, // Core clock.
    input wire a_we, // Port a write strobe.
    input wire [AW-1:0] a_addr, // Port a address.
    input wire [DW-1:0] a_wdata, // Port a write data.
    input wire b_we, // Port b write strobe.
    input wire [AW-1:0] b_addr, // Port b address.
    input wire [DW-1:0] b_wdata, // Port b write data.
    output reg [DW-1:0] b_rdata // Port b read data, one cycle after the address.
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Writes from both ports and the registered read of port b.
    always @(posedge clk) begin
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        b_rdata <= mem[b_addr];
    end
endmodule
`default_nettype wire

// >>> rtl/cd_ecc_core.v
// Contract
// - Read buffered symbols from RAM on a fixed frame tick from the core clock.
// - Finish first-stage check, correction and flag write before second stage starts.
// - First stage: none or one error clears flags; two errors corrected, flags set.
// - First stage: three or more errors leaves data alone and sets flags.
// - Second stage writes data and flags back; none or one error clears flags.
// - Second stage two errors both on flagged symbols: correct both, clear flags.
// - Second stage two errors with seven or more flags: no correction, pass flags.
// - Second stage two errors with only one position flagged: no correction.
// - Second stage two errors with no position flagged: no correction, pass flags.
// - Three or more errors: no correction; two or fewer flags sets all, else pass.
// - Symbol RAM is 2K by 8 and absorbs plus or minus four frames of jitter.
`include "ecc_map.vh"
`default_nettype none
module cd_ecc_core #(
    parameter FRAME_CYC = `FRAME_NS / `CLK_NS,
    parameter C2_DLY = `C2_DLY
) (
    input wire core_clk, // Core clock, 100 MHz.
    input wire rst, // Asynchronous reset, active high.
    input wire dm_we, // Upstream symbol write strobe.
    input wire [`RAM_AW-1:0] dm_addr, // Upstream write address, frame slot and symbol.
    input wire [`RAM_DW-1:0] dm_data, // Upstream symbol.
    input wire [`FRAME_AW-1:0] wr_frame, // Frame slot the upstream is writing.
    output reg busy_q, // Correction of a frame in progress.
    output reg slip_q, // One-cycle pulse when the read pointer was recentred.
    output reg c1_done_q, // One-cycle pulse when first-stage flags are stored.
    output reg [`C1_LEN-1:0] c1_flags_q, // First-stage flag register.
    output reg c2_done_q, // One-cycle pulse when a frame is finished.
    output reg [`FRAME_AW-1:0] c2_frame_q, // Frame slot of the finished frame.
    output reg [`C2_LEN-1:0] c2_flags_q // Second-stage flags of the finished codeword.
);
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_RD = 4'h1;
    localparam [3:0] S_ACC = 4'h2;
    localparam [3:0] S_CLS = 4'h3;
    localparam [3:0] S_CHN = 4'h4;
    localparam [3:0] S_INV = 4'h5;
    localparam [3:0] S_DEC = 4'h6;
    localparam [3:0] S_FXR = 4'h7;
    localparam [3:0] S_FXW = 4'h8;
    localparam [3:0] S_FLG = 4'h9;
    localparam [3:0] S_NEXT = 4'hA;
    localparam [5:0] DLY6 = C2_DLY[5:0];
    localparam [4:0] C1_LAST = `C1_LAST;
    localparam [4:0] C2_LAST = `C2_LAST;
    reg [23:0] div_q;
    reg [3:0] st_q;
    reg stage_q;
    reg [4:0] idx_q;
    reg [7:0] s0_q, s1_q, s2_q, s3_q;
    reg [31:0] flg_q;
    reg [31:0] oflag_q;
    reg single_q;
    reg [7:0] x_q, y_q, x1_q, x2_q, e1_q, e2_q;
    reg [4:0] p1_q, p2_q;
    reg [1:0] nroot_q;
    reg [1:0] errs_q;
    reg [1:0] fix_q;
    reg fixsel_q;
    reg [`FRAME_AW-1:0] rd_frame_q;
    // Multiply two field elements by shift and conditional reduction.
    function [7:0] gmul(input [7:0] a, input [7:0] b);
        reg [7:0] p, t;
        integer k;
        begin
            p = 8'h00;
            t = a;
            for (k = 0; k < 8; k = k + 1) begin
                if (b[k]) begin
                    p = p ^ t;
                end
                t = t[7] ? ({t[6:0], 1'b0} ^ `GF_POLY) : {t[6:0], 1'b0};
            end
            gmul = p;
        end
    endfunction
    // Count the flagged symbols of a codeword.
    function [5:0] popcnt(input [31:0] v);
        integer k;
        begin
            popcnt = 6'h00;
            for (k = 0; k < 32; k = k + 1) begin
                popcnt = popcnt + {5'h00, v[k]};
            end
        end
    endfunction
    // Map a symbol index to its RAM word; the second stage reaches back one slot per index.
    function [`RAM_AW-1:0] sym_addr(input st2, input [5:0] fr, input [4:0] i);
        reg [11:0] back;
        begin
            back = {1'b0, i} * DLY6;
            sym_addr = {(st2 ? fr - back[5:0] : fr), i};
        end
    endfunction
    wire tick = ({8'h00, div_q} == FRAME_CYC - 1);
    wire [7:0] rdata;
    wire [0:0] frdata;
    wire [4:0] last = stage_q ? C2_LAST : C1_LAST;
    wire [4:0] pos = (st_q == S_FXR || st_q == S_FXW) ? (fixsel_q ? p2_q : p1_q) : idx_q;
    wire [`RAM_AW-1:0] b_addr = sym_addr(stage_q, rd_frame_q, pos);
    wire [7:0] fix_val = rdata ^ (fixsel_q ? e2_q : e1_q);
    wire [5:0] fcnt = popcnt(flg_q);
    // Locator coefficients of the two-error case, left unnormalised so no division is needed.
    wire [7:0] dd = gmul(s0_q, s2_q) ^ gmul(s1_q, s1_q);
    wire [7:0] n1 = gmul(s0_q, s3_q) ^ gmul(s1_q, s2_q);
    wire [7:0] n2 = gmul(s1_q, s3_q) ^ gmul(s2_q, s2_q);
    wire dbl_root = (gmul(dd, gmul(x_q, x_q)) ^ gmul(n1, x_q) ^ n2) == 8'h00;
    wire sgl_root = (gmul(s0_q, x_q) == s1_q) && (gmul(s1_q, x_q) == s2_q) && (gmul(s2_q, x_q) == s3_q);
    wire root = single_q ? sgl_root : dbl_root;
    wire [7:0] e1w = gmul(s1_q ^ gmul(s0_q, x2_q), y_q);
    wire inv_hit = gmul(y_q, x1_q ^ x2_q) == 8'h01;
    // Read pointer recentring: distance of the writer from the nominal lag, modulo the slot count.
    wire [5:0] rd_next = rd_frame_q + 6'h01;
    wire [5:0] lag_err = wr_frame - rd_next - `RD_LAG;
    wire lag_ok = (lag_err <= `JIT_FRAMES) || (lag_err >= 6'h00 - `JIT_FRAMES);
    // Symbol store, 2K words of 8 bits.
    sym_ram #(.AW(`RAM_AW), .DW(`RAM_DW)) u_data (
        .clk(core_clk),
        .a_we(dm_we),
        .a_addr(dm_addr),
        .a_wdata(dm_data),
        .b_we(st_q == S_FXW),
        .b_addr(b_addr),
        .b_wdata(fix_val),
        .b_rdata(rdata)
    );
    // One erasure flag per stored symbol, shared by both stages.
    sym_ram #(.AW(`RAM_AW), .DW(1)) u_flag (
        .clk(core_clk),
        .a_we(1'b0),
        .a_addr({`RAM_AW{1'b0}}),
        .a_wdata(1'b0),
        .b_we(st_q == S_FLG),
        .b_addr(b_addr),
        .b_wdata(oflag_q[idx_q]),
        .b_rdata(frdata)
    );
    // Frame tick divider running from the core clock alone.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_q <= 24'h000000;
        end else if (tick) begin
            div_q <= 24'h000000;
        end else begin
            div_q <= div_q + 24'h000001;
        end
    end
    // Frame sequencer: syndromes, root search, decision, write-back of data and flags.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= S_IDLE;
            stage_q <= 1'b0;
            idx_q <= 5'h00;
            s0_q <= 8'h00;
            s1_q <= 8'h00;
            s2_q <= 8'h00;
            s3_q <= 8'h00;
            flg_q <= 32'h00000000;
            oflag_q <= 32'h00000000;
            single_q <= 1'b0;
            x_q <= 8'h01;
            y_q <= 8'h01;
            x1_q <= 8'h00;
            x2_q <= 8'h00;
            e1_q <= 8'h00;
            e2_q <= 8'h00;
            p1_q <= 5'h00;
            p2_q <= 5'h00;
            nroot_q <= 2'h0;
            errs_q <= 2'h0;
            fix_q <= 2'h0;
            fixsel_q <= 1'b0;
            rd_frame_q <= 6'h00;
            busy_q <= 1'b0;
            slip_q <= 1'b0;
            c1_done_q <= 1'b0;
            c1_flags_q <= 32'h00000000;
            c2_done_q <= 1'b0;
            c2_frame_q <= 6'h00;
            c2_flags_q <= 28'h0000000;
        end else begin
            slip_q <= 1'b0;
            c1_done_q <= 1'b0;
            c2_done_q <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    if (tick) begin
                        rd_frame_q <= lag_ok ? rd_next : wr_frame - `RD_LAG;
                        slip_q <= ~lag_ok;
                        busy_q <= 1'b1;
                        stage_q <= 1'b0;
                        idx_q <= C1_LAST;
                        st_q <= S_RD;
                    end
                end
                S_RD: begin
                    st_q <= S_ACC;
                end
                S_ACC: begin // Horner step: the symbol at index i weighs alpha to the power k times i.
                    s0_q <= s0_q ^ rdata;
                    s1_q <= gmul(s1_q, `GF_ALPHA) ^ rdata;
                    s2_q <= gmul(s2_q, 8'h04) ^ rdata;
                    s3_q <= gmul(s3_q, 8'h08) ^ rdata;
                    if (stage_q) begin
                        flg_q[idx_q] <= frdata[0];
                    end
                    if (idx_q == 5'h00) begin
                        st_q <= S_CLS;
                    end else begin
                        idx_q <= idx_q - 5'h01;
                        st_q <= S_RD;
                    end
                end
                S_CLS: begin
                    errs_q <= 2'h0;
                    single_q <= (dd == 8'h00);
                    x_q <= 8'h01;
                    y_q <= 8'h01;
                    nroot_q <= 2'h0;
                    idx_q <= 5'h00;
                    st_q <= ({s0_q, s1_q, s2_q, s3_q} == 32'h00000000) ? S_DEC : S_CHN;
                end
                S_CHN: begin
                    if (root) begin
                        if (nroot_q == 2'h0) begin
                            p1_q <= idx_q;
                            x1_q <= x_q;
                        end else begin
                            p2_q <= idx_q;
                            x2_q <= x_q;
                        end
                        if (nroot_q != 2'h3) begin
                            nroot_q <= nroot_q + 2'h1;
                        end
                    end
                    x_q <= gmul(x_q, `GF_ALPHA);
                    if (idx_q == last) begin
                        st_q <= S_INV;
                    end else begin
                        idx_q <= idx_q + 5'h01;
                    end
                end
                S_INV: begin // Root counts that do not match the case mean three or more errors.
                    if (single_q) begin
                        errs_q <= (nroot_q == 2'h1) ? 2'h1 : 2'h3;
                        e1_q <= s0_q;
                        st_q <= S_DEC;
                    end else if (nroot_q != 2'h2) begin
                        errs_q <= 2'h3;
                        st_q <= S_DEC;
                    end else if (inv_hit) begin
                        errs_q <= 2'h2;
                        e1_q <= e1w;
                        e2_q <= s0_q ^ e1w;
                        st_q <= S_DEC;
                    end else begin
                        y_q <= gmul(y_q, `GF_ALPHA);
                    end
                end
                S_DEC: begin
                    fixsel_q <= 1'b0;
                    fix_q <= 2'h0;
                    oflag_q <= 32'h00000000;
                    if (!stage_q) begin
                        case (errs_q)
                            2'h0: fix_q <= 2'h0;
                            2'h1: fix_q <= 2'h1;
                            2'h2: begin
                                fix_q <= 2'h2;
                                oflag_q <= 32'hFFFFFFFF;
                            end
                            default: oflag_q <= 32'hFFFFFFFF;
                        endcase
                    end else begin
                        case (errs_q)
                            2'h0: fix_q <= 2'h0;
                            2'h1: fix_q <= 2'h1;
                            2'h2: begin
                                if (fcnt >= `C2_FLAG_MANY) begin
                                    oflag_q <= flg_q;
                                end else if (flg_q[p1_q] && flg_q[p2_q]) begin
                                    fix_q <= 2'h2;
                                end else begin
                                    oflag_q <= flg_q;
                                end
                            end
                            default: begin
                                oflag_q <= (fcnt <= `C2_FLAG_FEW) ? {4'h0, 28'hFFFFFFF} : flg_q;
                            end
                        endcase
                    end
                    idx_q <= 5'h00;
                    st_q <= S_FXR;
                end
                S_FXR: begin
                    st_q <= (fix_q == 2'h0) ? S_FLG : S_FXW;
                end
                S_FXW: begin // Read-modify-write of one symbol; the second fix reuses the same two states.
                    if (!fixsel_q && fix_q == 2'h2) begin
                        fixsel_q <= 1'b1;
                        st_q <= S_FXR;
                    end else begin
                        st_q <= S_FLG;
                    end
                end
                S_FLG: begin
                    if (idx_q == last) begin
                        st_q <= S_NEXT;
                    end else begin
                        idx_q <= idx_q + 5'h01;
                    end
                end
                S_NEXT: begin
                    s0_q <= 8'h00;
                    s1_q <= 8'h00;
                    s2_q <= 8'h00;
                    s3_q <= 8'h00;
                    if (!stage_q) begin
                        c1_flags_q <= oflag_q;
                        c1_done_q <= 1'b1;
                        stage_q <= 1'b1;
                        idx_q <= C2_LAST;
                        st_q <= S_RD;
                    end else begin
                        c2_flags_q <= oflag_q[`C2_LEN-1:0];
                        c2_frame_q <= rd_frame_q;
                        c2_done_q <= 1'b1;
                        busy_q <= 1'b0;
                        st_q <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> tb/cd_ecc_props.sv
`default_nettype none
module cd_ecc_props #(
    parameter FRAME_CYC = 600
) (
    input wire logic core_clk, // Core clock.
    input wire logic rst, // Reset, active high.
    input wire logic busy_q, // Frame in progress.
    input wire logic slip_q, // Read pointer recentred.
    input wire logic c1_done_q, // First stage stored.
    input wire logic [31:0] c1_flags_q, // First-stage flags.
    input wire logic c2_done_q, // Frame finished.
    input wire logic [5:0] c2_frame_q, // Finished slot.
    input wire logic [27:0] c2_flags_q // Second-stage flags.
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int MAX_RUN = 590;
    logic c1_seen_q;
    logic rose_seen_q;
    logic busy_d1_q;
    logic [15:0] gap_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Remembers the first stage of the running frame and counts cycles between frame starts.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            c1_seen_q <= 1'b0;
            rose_seen_q <= 1'b0;
            busy_d1_q <= 1'b0;
            gap_q <= 16'h0000;
        end else begin
            busy_d1_q <= busy_q;
            c1_seen_q <= c1_done_q | (c1_seen_q & ~c2_done_q);
            rose_seen_q <= rose_seen_q | (busy_q & ~busy_d1_q);
            gap_q <= (busy_q & ~busy_d1_q) ? 16'h0001 : gap_q + 16'h0001;
        end
    end
    AST_TICK_PERIOD: assert property ((busy_q && !busy_d1_q && rose_seen_q) |-> int'(gap_q) == FRAME_CYC)
        else $error("frame starts not one tick apart");
    AST_RUN_BOUNDED: assert property ($rose(busy_q) |-> ##[1:MAX_RUN] c2_done_q)
        else $error("frame not finished in time");
    AST_C1_BEFORE_C2: assert property (c2_done_q |-> c1_seen_q)
        else $error("frame finished without first stage");
    AST_C1_IN_FRAME: assert property (c1_done_q |-> busy_q && !c2_done_q)
        else $error("first stage outside a frame");
    AST_C1_FLAGS_WHOLE: assert property (c1_done_q |-> (c1_flags_q == '0 || c1_flags_q == '1))
        else $error("first-stage flags split within a codeword");
    AST_C1_FLAGS_HELD: assert property (!c1_done_q |-> $stable(c1_flags_q))
        else $error("first-stage flags moved without a store");
    AST_C2_HELD: assert property (!c2_done_q |-> $stable(c2_flags_q) && $stable(c2_frame_q))
        else $error("second-stage result moved without a finish");
    AST_DONE_PULSE: assert property (c2_done_q |=> !c2_done_q && !busy_q)
        else $error("finish pulse too long or busy stuck");
    AST_BUSY_END: assert property ($fell(busy_q) |-> c2_done_q || $past(c2_done_q))
        else $error("busy dropped without a finish");
    AST_SLIP_START: assert property (slip_q |-> $rose(busy_q) ##1 !slip_q)
        else $error("recentre pulse away from a frame start");
    cover property (c1_done_q && c1_flags_q == '1);
    cover property (slip_q);
    cover property (c2_done_q && c2_flags_q == '1);
endmodule
bind cd_ecc_core cd_ecc_props #(.FRAME_CYC(FRAME_CYC)) i_props (.core_clk(core_clk), .rst(rst),
    .busy_q(busy_q), .slip_q(slip_q), .c1_done_q(c1_done_q), .c1_flags_q(c1_flags_q),
    .c2_done_q(c2_done_q), .c2_frame_q(c2_frame_q), .c2_flags_q(c2_flags_q));
`default_nettype wire

// >>> tb/demod_writer.sv
`default_nettype none
module demod_writer (
    input wire logic core_clk, // Core clock.
    output logic dm_we, // Write strobe.
    output logic [10:0] dm_addr, // Slot and symbol.
    output logic [7:0] dm_data, // Symbol value.
    output logic [5:0] wr_frame // Slot being filled.
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle at time zero, eight slots ahead of the first slot read.
    initial begin
        dm_we = 1'b0;
        dm_addr = 11'h000;
        dm_data = 8'h00;
        wr_frame = 6'h09;
    end
    // One write; afterwards the data line shows the inverse so stale data never looks valid.
    task automatic put(input logic [10:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        dm_we <= 1'b1;
        dm_addr <= addr;
        dm_data <= data;
        @(posedge core_clk);
        dm_we <= 1'b0;
        dm_data <= ~data;
    endtask
    // Moves the writer's slot, which may push the reader out of its jitter window.
    task automatic set_slot(input logic [5:0] slot);
        @(posedge core_clk);
        wr_frame <= slot;
    endtask
endmodule
`default_nettype wire

// >>> tb/cd_c1_c2_error_corrector_bench.sv
`default_nettype none
module cd_c1_c2_error_corrector_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TICK = 600;
    logic core_clk;
    logic rst;
    logic dm_we;
    logic [10:0] dm_addr;
    logic [7:0] dm_data;
    logic [5:0] wr_frame;
    logic busy_q, slip_q, c1_done_q, c2_done_q;
    logic [31:0] c1_flags_q;
    logic [5:0] c2_frame_q;
    logic [27:0] c2_flags_q;
    logic [31:0] pre_err [64];
    logic [31:0] late_err [64];
    int mismatches;
    int tests_run;
    // Clock of 10 ns.
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;
    cd_ecc_core #(.FRAME_CYC(TICK)) i_cd_ecc_core (.core_clk(core_clk), .rst(rst), .dm_we(dm_we),
        .dm_addr(dm_addr), .dm_data(dm_data), .wr_frame(wr_frame), .busy_q(busy_q), .slip_q(slip_q),
        .c1_done_q(c1_done_q), .c1_flags_q(c1_flags_q), .c2_done_q(c2_done_q), .c2_frame_q(c2_frame_q),
        .c2_flags_q(c2_flags_q));
    demod_writer writer (.core_clk(core_clk), .dm_we(dm_we), .dm_addr(dm_addr), .dm_data(dm_data),
        .wr_frame(wr_frame));
    // A slot is flagged by the first stage when it holds two or more loaded errors.
    function automatic logic flagged(input int s);
        return $countones(pre_err[s & 63]) >= 2;
    endfunction
    // Expected second-stage flags of the codeword finished on slot r.
    function automatic logic [27:0] c2_expect(input int r);
        logic [27:0] mask;
        int nerr, nhit, s;
        nerr = 0;
        nhit = 0;
        for (int i = 0; i < 28; i++) begin
            s = (r - i) & 63;
            mask[i] = flagged(s);
            if (($countones(pre_err[s]) >= 3 && pre_err[s][i]) || late_err[s][i]) begin
                nerr++;
                nhit += mask[i];
            end
        end
        if (nerr <= 1) return '0;
        if (nerr == 2) return ($countones(mask) < 7 && nhit == 2) ? '0 : mask;
        return ($countones(mask) <= 2) ? '1 : mask;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One frame: sets the writer slot, judges the start, the finish, the first-stage flags and, with chk2, the second-stage flags, then adds late errors.
    task automatic run_tick(input int r, input int lead, input logic slip_exp, input bit chk2);
        int n;
        n = 0;
        writer.set_slot(6'(lead));
        do begin
            @(negedge core_clk);
            n++;
        end while (busy_q !== 1'b1 && n < 2 * TICK);
        check(32'(busy_q), 32'h00000001);
        check(32'(slip_q), 32'(slip_exp));
        do begin
            @(negedge core_clk);
            n++;
        end while (c2_done_q !== 1'b1 && n < 2 * TICK);
        check(32'(c2_done_q), 32'h00000001);
        check(32'(c2_frame_q), 32'(r & 63));
        check(c1_flags_q, flagged(r) ? 32'hFFFFFFFF : 32'h00000000);
        if (chk2) check(32'(c2_flags_q), 32'(c2_expect(r)));
        for (int i = 1; i < 28; i++) begin
            if (late_err[r & 63][i]) writer.put({6'(r), 5'(i)}, 8'h40 | 8'(i));
        end
    endtask
    task automatic test_first_stage();
        for (int r = 1; r < 28; r++) run_tick(r, r + 8, 1'b0, 1'b0);
        $display("First stage classes done");
    endtask
    task automatic test_second_stage();
        for (int r = 28; r < 64; r++) run_tick(r, r + 8, 1'b0, 1'b1);
        $display("Second stage cases done");
    endtask
    task automatic test_recentre();
        run_tick(22, 30, 1'b1, 1'b0);
        run_tick(23, 31, 1'b0, 1'b0);
        $display("Recentre done");
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Cuts a hang short well after the expected run length.
    initial begin
        repeat (60000) @(posedge core_clk);
        mismatches++;
        stop_test();
    end
    // Error map, RAM load under a second reset, then the scenarios.
    initial begin
        rst = 1'b1;
        mismatches = 0;
        tests_run = 0;
        for (int s = 0; s < 64; s++) begin
            pre_err[s] = 32'h70000000 & {32{s >= 41 && s <= 47}};
            late_err[s] = 32'h00000000;
        end
        pre_err[2] = 32'h04000000;
        pre_err[3] = 32'h0A000000;
        pre_err[4] = 32'h70000000;
        pre_err[10] = 32'h74800000;
        pre_err[20] = 32'h70010000;
        pre_err[41] = 32'h70000080;
        pre_err[42] = 32'h70000040;
        pre_err[45] = 32'h70000020;
        late_err[32] = 32'h00000006;
        late_err[33] = 32'h00000002;
        late_err[34] = 32'h00000002;
        late_err[37] = 32'h00000008;
        late_err[38] = 32'h00000004;
        late_err[39] = 32'h00000002;
        late_err[48] = 32'h00000004;
        late_err[49] = 32'h00000002;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b1;
        for (int a = 0; a < 2048; a++) writer.put(11'(a), pre_err[a >> 5][a & 31] ? 8'h80 | 8'(a & 31) : 8'h00);
        @(posedge core_clk);
        rst <= 1'b0;
        test_first_stage();
        test_second_stage();
        test_recentre();
        stop_test();
    end
endmodule
`default_nettype wire
